// >>> src/snp_cfg.svh
// Constants of the shift, normalize and pack unit
`ifndef SNP_CFG_SVH
`define SNP_CFG_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SNP_OP_LCIRC   6'o20
`define SNP_OP_RSIGN   6'o21
`define SNP_OP_NOML    6'o22
`define SNP_OP_NOMR    6'o23
`define SNP_OP_NORM    6'o24
`define SNP_OP_RNORM   6'o25
`define SNP_OP_UNPACK  6'o26
`define SNP_OP_PACK    6'o27
`define SNP_OP_MASK    6'o43

// ----------------------------------------------------------------
// Field positions and limits
// ----------------------------------------------------------------
`define SNP_SIGN_BIT    59
`define SNP_EXP_HI      58
`define SNP_EXP_LO      48
`define SNP_COEF_TOP    47
`define SNP_RSHIFT_MAX  12'o0177
`define SNP_ZERO_COUNT  18'o000060
`define SNP_EXP_BIAS    12'o2000
`define SNP_UFLOW_LIM   13'sh1_C00
`define SNP_INF_CODE    11'o1777
`define SNP_IND_CODE    11'o1777
`define SNP_IND_TOP     2'b01

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SNP_SHIFT_NS    25
`define SNP_CLK_NS      25
`define SNP_SHIFT_CYC   ((`SNP_SHIFT_NS + `SNP_CLK_NS - 1) / `SNP_CLK_NS)

`endif

// >>> src/snp_pkg.sv
// Types of the shift, normalize and pack unit
package snp_pkg;

	// Sequence states, Gray coded along the usual path
	typedef enum logic [1:0] {
		SNP_IDLE   = 2'b00,
		SNP_SETUP  = 2'b01,
		SNP_SHIFT  = 2'b11,
		SNP_COMMIT = 2'b10
	} snp_state_t;

endpackage

// >>> src/snp_shift_if.sv
// Interface between the sequencer and the shift network
`timescale 1ns/1ps
`default_nettype none

interface snp_shift_if;
	logic [59:0] data;
	logic [6:0]  count;
	logic        right;
	logic        fill_one;
	logic        block;
	logic [59:0] result;

	modport seq (output data, output count, output right, output fill_one, output block, input result);
	modport net (input data, input count, input right, input fill_one, input block, output result);
endinterface

`default_nettype wire

// >>> src/snp_shift_net.sv
// Shift network: circular left, sign or forced-one filled right
`timescale 1ns/1ps
`default_nettype none

module snp_shift_net
	import snp_pkg::*;
(
	snp_shift_if.net sh
);
	logic [119:0] dbl;
	logic [119:0] ext;
	logic [5:0]   cnt;

	// Circular left by doubling the word, right by extending it
	always_comb begin
		cnt = (sh.count >= 7'd60) ? 6'd59 : sh.count[5:0];
		dbl = {sh.data, sh.data} << cnt;
		ext = {{60{sh.fill_one | sh.data[59]}}, sh.data};
		if (sh.block) begin
			sh.result = 60'h000_0000_0000_0000;
		end else if (sh.right) begin
			if (sh.count >= 7'd60) begin
				sh.result = ext[119:60];
			end else begin
				sh.result = ext[cnt +: 60];
			end
		end else begin
			sh.result = dbl[119:60];
		end
	end
endmodule

`default_nettype wire

// >>> src/snp_norm_net.sv
// Normalize network: leading zero count of a sign-corrected 48-bit coefficient
`timescale 1ns/1ps
`default_nettype none

module snp_norm_net (
	input  wire logic [47:0] coef_i,
	output logic      [5:0]  count_o,
	output logic             zero_o
);
	logic found;

	// Count positions until the first one reaches bit 47
	always_comb begin
		count_o = 6'd48;
		found   = 1'b0;
		for (int i = 47; i >= 0; i--) begin
			if (!found && coef_i[i]) begin
				count_o = 6'(47 - i);
				found   = 1'b1;
			end
		end
		if (!found) begin
			count_o = 6'd48;
		end
		zero_o = (coef_i == 48'h0000_0000_0000);
	end
endmodule

`default_nettype wire

// >>> src/snp_unit.sv
// Shift, normalize, unpack, pack and mask unit
`timescale 1ns/1ps
`default_nettype none
`include "snp_cfg.svh"

module snp_unit
	import snp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        clk_en_i,
	input  wire logic        start_i,
	input  wire logic [5:0]  opcode_i,
	input  wire logic [5:0]  immediate_shift_field_i,
	input  wire logic [59:0] first_operand_reg_i,
	input  wire logic [59:0] second_operand_reg_i,
	input  wire logic [17:0] index_count_reg_i,
	input  wire logic        exit_mode_select_i,
	input  wire logic        exchange_jump_enable_i,
	input  wire logic        next_instruction_fetch_i,
	input  wire logic        error_exit_clear_i,
	output logic             busy_o,
	output logic             common_write_phase_o,
	output logic [59:0]      dest_operand_reg_o,
	output logic             index_write_o,
	output logic [17:0]      index_count_reg_o,
	output logic             error_exit_flop_o,
	output logic             instruction_hold_clear_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		snp_state_t  state;
		logic [5:0]  op;
		logic [59:0] work;          // Coefficient work word
		logic [6:0]  shift_count_reg;
		logic        right;
		logic        fill_one;
		logic        block;
		logic        special;       // Infinite or indefinite operand
		logic        uflow;
		logic [17:0] index_val;
		logic        index_wr;
		logic [10:0] exp_out;       // Biased exponent of normalize result
		logic        sign;
		logic        round;
		logic [59:0] result;
		logic        commit;
		logic        exit_pend;
		logic        error_exit_flop;
		logic        hold_clear;
	} snp_regs_t;

	snp_regs_t r;
	snp_regs_t next_r;

	snp_shift_if sh ();
	logic [5:0]  norm_count;
	logic        norm_zero;
	logic [47:0] norm_coef;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// True exponent of a floating word, sign-extended to 13 bits
	function automatic logic signed [12:0] true_exp(input logic [59:0] w);
		logic [10:0] e;
		e = w[59] ? ~w[58:48] : w[58:48];
		true_exp = $signed({2'b00, e}) - $signed({1'b0, `SNP_EXP_BIAS});
	endfunction

	// Infinite or indefinite exponent code
	function automatic logic is_special(input logic [59:0] w);
		logic [10:0] e;
		e = w[59] ? ~w[58:48] : w[58:48];
		is_special = (e == `SNP_INF_CODE) || (e[10:9] == 2'b11);
	endfunction

	// Pack coefficient and true exponent into floating format
	function automatic logic [59:0] pack_word(input logic [59:0] c, input logic [12:0] x);
		logic [10:0] b;
		b = 11'(x + 13'(`SNP_EXP_BIAS));
		pack_word = {c[59], c[59] ? ~b : b, c[47:0]};
	endfunction

	// ----------------------------------------------------------------
	// Shift and normalize networks
	// ----------------------------------------------------------------
	assign sh.data     = r.work;
	assign sh.count    = r.shift_count_reg;
	assign sh.right    = r.right;
	assign sh.fill_one = r.fill_one;
	assign sh.block    = r.block;

	snp_shift_net u_shift (
		.sh (sh.net)
	);

	// Coefficient folded against its sign, so the network counts zeros
	assign norm_coef = second_operand_reg_i[47:0] ^ {48{second_operand_reg_i[59]}};

	snp_norm_net u_norm (
		.coef_i  (norm_coef),
		.count_o (norm_count),
		.zero_o  (norm_zero)
	);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb begin
		logic signed [12:0] ex;
		logic signed [12:0] fin;
		logic [17:0]        bj;
		logic [59:0]        rnd;
		ex     = 13'sd0;
		fin    = 13'sd0;
		bj     = index_count_reg_i;
		rnd    = 60'h000_0000_0000_0000;
		next_r = r;
		next_r.commit     = 1'b0;
		next_r.hold_clear = 1'b0;

		// Error exit taken at the next instruction fetch
		if (error_exit_clear_i) begin
			next_r.error_exit_flop = 1'b0;
		end
		if (r.exit_pend && next_instruction_fetch_i) begin
			next_r.error_exit_flop = 1'b1;
			next_r.hold_clear      = 1'b1;
			next_r.exit_pend       = 1'b0;
		end

		unique case (r.state)
			SNP_IDLE: begin
				if (start_i) begin
					next_r.op       = opcode_i;
					next_r.right    = 1'b0;
					next_r.fill_one = 1'b0;
					next_r.block    = 1'b0;
					next_r.special  = 1'b0;
					next_r.uflow    = 1'b0;
					next_r.round    = 1'b0;
					next_r.index_wr = 1'b0;
					next_r.index_val = 18'h0_0000;
					next_r.work     = second_operand_reg_i;
					next_r.shift_count_reg = {1'b0, immediate_shift_field_i};
					next_r.state    = SNP_SETUP;
					case (opcode_i)
						`SNP_OP_LCIRC: begin
							next_r.work = first_operand_reg_i;
						end
						`SNP_OP_RSIGN: begin
							next_r.work  = first_operand_reg_i;
							next_r.right = 1'b1;
						end
						`SNP_OP_NOML, `SNP_OP_NOMR: begin
							// Negative index uses its ones complement
							if (bj[17]) begin
								bj = ~bj;
							end
							next_r.right = bj[17] ^ index_count_reg_i[17] ^
								(opcode_i == `SNP_OP_NOMR);
							next_r.shift_count_reg = (bj > 18'(`SNP_RSHIFT_MAX)) ? 7'h7F : bj[6:0];
							next_r.block = next_r.right && (bj > 18'(`SNP_RSHIFT_MAX));
							if (!next_r.right) begin
								next_r.shift_count_reg = 7'(bj % 18'd60);
							end
						end
						`SNP_OP_NORM, `SNP_OP_RNORM: begin
							next_r.index_wr = 1'b1;
							if (is_special(second_operand_reg_i)) begin
								next_r.special = 1'b1;
								next_r.shift_count_reg = 7'h00;
								next_r.index_val = 18'h0_0000;
								next_r.exit_pend = exit_mode_select_i && exchange_jump_enable_i;
							end else begin
								ex  = true_exp(second_operand_reg_i);
								fin = ex - 13'(norm_count);
								next_r.sign = second_operand_reg_i[59];
								next_r.exp_out = 11'(fin + 13'(`SNP_EXP_BIAS));
								next_r.shift_count_reg = {1'b0, norm_count};
								next_r.index_val = 18'(norm_count);
								next_r.work = {{12{second_operand_reg_i[59]}}, second_operand_reg_i[47:0]};
								if (opcode_i == `SNP_OP_RNORM) begin
									next_r.round = 1'b1;
								end
								if (fin <= $signed(`SNP_UFLOW_LIM)) begin
									next_r.uflow = 1'b1;
								end
								if (norm_zero && (opcode_i == `SNP_OP_NORM)) begin
									next_r.uflow     = 1'b1;
									next_r.index_val = `SNP_ZERO_COUNT;
								end
							end
						end
						`SNP_OP_UNPACK: begin
							next_r.index_wr  = 1'b1;
							next_r.index_val = 18'($signed(true_exp(second_operand_reg_i)));
							next_r.shift_count_reg = 7'h00;
						end
						`SNP_OP_PACK: begin
							next_r.shift_count_reg = 7'h00;
						end
						`SNP_OP_MASK: begin
							next_r.work     = 60'h000_0000_0000_0000;
							next_r.right    = 1'b1;
							next_r.fill_one = 1'b1;
						end
						default: begin
							next_r.state = SNP_IDLE;
						end
					endcase
				end
			end
			SNP_SETUP: begin
				next_r.state = SNP_SHIFT;
			end
			SNP_SHIFT: begin
				next_r.result = sh.result;
				case (r.op)
					`SNP_OP_NORM, `SNP_OP_RNORM: begin
						if (r.special) begin
							next_r.result = r.work;
						end else if (r.uflow) begin
							next_r.result = 60'h000_0000_0000_0000;
						end else begin
							// Round bit sits one place below the LSB
							rnd = sh.result;
							if (r.round) begin
								rnd = r.sign ? 60'(sh.result - 60'd0) : sh.result;
								if (r.shift_count_reg != 7'h00) begin
									rnd[r.shift_count_reg[5:0] - 6'd1] = ~r.sign;
								end
							end
							next_r.result = {r.sign, r.sign ? ~r.exp_out : r.exp_out, rnd[47:0]};
						end
					end
					`SNP_OP_UNPACK: begin
						next_r.result = {{12{r.work[59]}}, r.work[47:0]};
					end
					`SNP_OP_PACK: begin
						next_r.result = pack_word(r.work, index_count_reg_i[12:0]);
					end
					default: begin
					end
				endcase
				next_r.state = SNP_COMMIT;
			end
			SNP_COMMIT: begin
				next_r.commit = 1'b1;
				next_r.state  = SNP_IDLE;
			end
			default: begin
				next_r.state = SNP_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			r <= '0;
		end else if (clk_en_i) begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign busy_o                   = (r.state != SNP_IDLE);
	assign common_write_phase_o     = r.commit;
	assign dest_operand_reg_o       = r.result;
	assign index_write_o            = r.commit && r.index_wr;
	assign index_count_reg_o        = r.index_val;
	assign error_exit_flop_o        = r.error_exit_flop;
	assign instruction_hold_clear_o = r.hold_clear;
endmodule

`default_nettype wire

// >>> verification/snp_unit_assertions.sv
// Concurrent checks on the ports of the shift, normalize and pack unit
`timescale 1ns/1ps
`default_nettype none
`include "snp_cfg.svh"

module snp_unit_assertions (
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        clk_en_i,
	input  wire logic        start_i,
	input  wire logic [5:0]  opcode_i,
	input  wire logic [5:0]  immediate_shift_field_i,
	input  wire logic [59:0] first_operand_reg_i,
	input  wire logic [59:0] second_operand_reg_i,
	input  wire logic [17:0] index_count_reg_i,
	input  wire logic        next_instruction_fetch_i,
	input  wire logic        busy_o,
	input  wire logic        common_write_phase_o,
	input  wire logic [59:0] dest_operand_reg_o,
	input  wire logic        index_write_o,
	input  wire logic        error_exit_flop_o,
	input  wire logic        instruction_hold_clear_o
);
	logic        take;
	logic        op_ok;
	logic [5:0]  op_q;
	logic [5:0]  imm_q;
	logic [59:0] xj_q;
	logic [59:0] xk_q;
	logic [17:0] bj_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// Rotate helper for the expected circular result
	function automatic logic [59:0] rotl(input logic [59:0] v, input logic [5:0] n);
		logic [119:0] w;
		w = {v, v} << n;
		return w[119:60];
	endfunction

	// Operands captured at the taking edge
	assign take  = start_i && !busy_o && clk_en_i;
	assign op_ok = opcode_i inside {[`SNP_OP_LCIRC:`SNP_OP_PACK], `SNP_OP_MASK};
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			op_q  <= 6'h00;
			imm_q <= 6'h00;
			xj_q  <= 60'h000_0000_0000_0000;
			xk_q  <= 60'h000_0000_0000_0000;
			bj_q  <= 18'h0_0000;
		end else if (take) begin
			op_q  <= opcode_i;
			imm_q <= immediate_shift_field_i;
			xj_q  <= first_operand_reg_i;
			xk_q  <= second_operand_reg_i;
			bj_q  <= index_count_reg_i;
		end
	end

	sequence s_take;
		take && op_ok;
	endsequence

	a_write_latency: assert property (s_take |-> ##4 common_write_phase_o)
		else $error("result write not four cycles after start");
	a_busy_hold: assert property (s_take |-> ##1 busy_o [*3])
		else $error("busy dropped during operation");
	a_pulse_once: assert property (common_write_phase_o |=> !common_write_phase_o)
		else $error("write pulse longer than one cycle");
	a_index_pair: assert property (common_write_phase_o |->
		index_write_o == (op_q inside {`SNP_OP_NORM, `SNP_OP_RNORM, `SNP_OP_UNPACK}))
		else $error("index write does not match opcode");
	a_rotate_left: assert property (common_write_phase_o && op_q == `SNP_OP_LCIRC |->
		dest_operand_reg_o == rotl(xj_q, imm_q))
		else $error("circular left result wrong");
	a_right_sign: assert property (common_write_phase_o && op_q == `SNP_OP_RSIGN |->
		dest_operand_reg_o == 60'($signed(xj_q) >>> imm_q))
		else $error("sign filled right result wrong");
	a_rshift_block: assert property (common_write_phase_o && op_q == `SNP_OP_NOMR && !bj_q[17]
		&& bj_q > 18'h0_007F |-> dest_operand_reg_o == 60'h000_0000_0000_0000)
		else $error("long right shift not zero");
	a_unpack_coef: assert property (common_write_phase_o && op_q == `SNP_OP_UNPACK |->
		dest_operand_reg_o == {{12{xk_q[59]}}, xk_q[47:0]})
		else $error("unpack coefficient wrong");
	a_mask_form: assert property (common_write_phase_o && op_q == `SNP_OP_MASK |->
		dest_operand_reg_o == ~(60'hFFF_FFFF_FFFF_FFFF >> imm_q))
		else $error("mask word wrong");
	a_error_fetch: assert property ($rose(error_exit_flop_o) |->
		instruction_hold_clear_o && $past(next_instruction_fetch_i))
		else $error("error exit not tied to fetch");
endmodule

`default_nettype wire

// >>> verification/snp_fetch_model.sv
// Instruction issue model: begins the next fetch after each result write
`timescale 1ns/1ps
`default_nettype none

module snp_fetch_model (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic common_write_phase_i,
	output logic      next_instruction_fetch_o
);
	// Next fetch starts the cycle after common write
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			next_instruction_fetch_o <= 1'b0;
		end else begin
			next_instruction_fetch_o <= common_write_phase_i;
		end
	end
endmodule

`default_nettype wire

// >>> verification/tb.sv
// Self-checking testbench of the shift, normalize and pack unit
`timescale 1ns/1ps
`default_nettype none
`include "snp_cfg.svh"

module tb;
	logic        clk_i     = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        start_i   = 1'b0;
	logic [5:0]  opcode_i  = 6'h00;
	logic [5:0]  imm       = 6'h00;
	logic [59:0] xop       = 60'h000_0000_0000_0000;
	logic [17:0] bj        = 18'h0_0000;
	logic        exit_mode = 1'b0;
	logic        jump_en   = 1'b0;
	logic        err_clr   = 1'b0;
	logic        busy;
	logic        cwp;
	logic [59:0] dest;
	logic        idx_wr;
	logic [17:0] idx;
	logic        err_ff;
	logic        hold_clr;
	logic        fetch;
	int          err_total = 0;
	int          tests_run = 0;

	always #12.5 clk_i = ~clk_i;

	snp_unit i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .start_i(start_i),
		.opcode_i(opcode_i), .immediate_shift_field_i(imm), .first_operand_reg_i(xop),
		.second_operand_reg_i(xop), .index_count_reg_i(bj), .exit_mode_select_i(exit_mode),
		.exchange_jump_enable_i(jump_en), .next_instruction_fetch_i(fetch), .error_exit_clear_i(err_clr),
		.busy_o(busy), .common_write_phase_o(cwp), .dest_operand_reg_o(dest), .index_write_o(idx_wr),
		.index_count_reg_o(idx), .error_exit_flop_o(err_ff), .instruction_hold_clear_o(hold_clr));

	snp_fetch_model i_fetch (.clk_i(clk_i), .reset_n_i(reset_n_i), .common_write_phase_i(cwp),
		.next_instruction_fetch_o(fetch));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [59:0] seen, input logic [59:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("Checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Issue one instruction and wait for its result write
	task automatic run_op(input logic [5:0] op, input logic [5:0] n, input logic [59:0] a, input logic [17:0] b);
		@(posedge clk_i);
		#2;
		opcode_i = op;
		imm      = n;
		xop      = a;
		bj       = b;
		start_i  = 1'b1;
		@(posedge clk_i);
		#2;
		start_i = 1'b0;
		for (int i = 0; i < 12 && cwp !== 1'b1; i++) begin
			@(posedge clk_i);
			#2;
		end
		check("write pulse", 60'(cwp), 60'h000_0000_0000_0001);
		check("index write", 60'(idx_wr), 60'(op inside {`SNP_OP_NORM, `SNP_OP_RNORM, `SNP_OP_UNPACK}));
		$display("Test opcode %o done", op);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		#50_000;
		err_total++;
		end_sim();
	end

	initial begin
		repeat (4) @(posedge clk_i);
		#2;
		reset_n_i = 1'b1;
		run_op(`SNP_OP_LCIRC, 6'h05, 60'h800_0000_0000_0001, 18'h0_0000);
		check("rotate", dest, 60'h000_0000_0000_0030);
		run_op(`SNP_OP_RSIGN, 6'h04, 60'h800_0000_0000_00F0, 18'h0_0000);
		check("right", dest, 60'hF80_0000_0000_000F);
		run_op(`SNP_OP_NOML, 6'h00, 60'h800_0000_0000_0001, 18'h0_0005);
		check("nom left pos", dest, 60'h000_0000_0000_0030);
		run_op(`SNP_OP_NOML, 6'h00, 60'h800_0000_0000_0001, 18'h3_FFFC);
		check("nom left neg", dest, 60'hF00_0000_0000_0000);
		run_op(`SNP_OP_NOMR, 6'h00, 60'h800_0000_0000_0001, 18'h0_0004);
		check("nom right pos", dest, 60'hF80_0000_0000_0000);
		run_op(`SNP_OP_NOMR, 6'h00, 60'h800_0000_0000_0001, 18'h3_FFFA);
		check("nom right neg", dest, 60'h000_0000_0000_0030);
		run_op(`SNP_OP_NOMR, 6'h00, 60'h800_0000_0000_0001, 18'h0_007F);
		check("right 177", dest, 60'hFFF_FFFF_FFFF_FFFF);
		run_op(`SNP_OP_NOMR, 6'h00, 60'h800_0000_0000_0001, 18'h0_0080);
		check("right 200", dest, 60'h000_0000_0000_0000);
		run_op(`SNP_OP_NORM, 6'h00, 60'h400_0000_0000_00FF, 18'h0_0000);
		check("normalize", dest, 60'h3D8_FF00_0000_0000);
		check("norm count", 60'(idx), 60'h000_0000_0000_0028);
		run_op(`SNP_OP_RNORM, 6'h00, 60'h400_0000_0000_00FF, 18'h0_0000);
		check("round norm", dest, 60'h3D8_FF80_0000_0000);
		check("round count", 60'(idx), 60'h000_0000_0000_0028);
		run_op(`SNP_OP_NORM, 6'h00, 60'h008_0000_0000_00FF, 18'h0_0000);
		check("underflow", dest, 60'h000_0000_0000_0000);
		check("uflow count", 60'(idx), 60'h000_0000_0000_0028);
		run_op(`SNP_OP_NORM, 6'h00, 60'h400_0000_0000_0000, 18'h0_0000);
		check("zero coef", dest, 60'h000_0000_0000_0000);
		check("zero count", 60'(idx), 60'h000_0000_0000_0030);
		run_op(`SNP_OP_NORM, 6'h00, 60'h7FF_0000_0000_1234, 18'h0_0000);
		check("infinite", dest, 60'h7FF_0000_0000_1234);
		check("inf count", 60'(idx), 60'h000_0000_0000_0000);
		run_op(`SNP_OP_MASK, 6'h0C, 60'h000_0000_0000_0000, 18'h0_0000);
		check("mask 12", dest, 60'hFFF_0000_0000_0000);
		check("no exit", 60'(err_ff), 60'h000_0000_0000_0000);
		exit_mode = 1'b1;
		jump_en   = 1'b1;
		run_op(`SNP_OP_NORM, 6'h00, 60'h7FF_0000_0000_1234, 18'h0_0000);
		for (int i = 0; i < 8 && err_ff !== 1'b1; i++) begin
			@(posedge clk_i);
			#2;
		end
		check("exit flop", 60'(err_ff), 60'h000_0000_0000_0001);
		check("hold clear", 60'(hold_clr), 60'h000_0000_0000_0001);
		exit_mode = 1'b0;
		jump_en   = 1'b0;
		err_clr   = 1'b1;
		@(posedge clk_i);
		#2;
		err_clr = 1'b0;
		check("exit cleared", 60'(err_ff), 60'h000_0000_0000_0000);
		run_op(`SNP_OP_UNPACK, 6'h00, 60'h405_0000_1234_5678, 18'h0_0000);
		check("unpack", dest, 60'h000_0000_1234_5678);
		check("unpack exp", 60'(idx), 60'h000_0000_0000_0005);
		run_op(`SNP_OP_UNPACK, 6'h00, 60'hBFA_0000_1234_5678, 18'h0_0000);
		check("unpack neg", dest, 60'hFFF_0000_1234_5678);
		run_op(`SNP_OP_PACK, 6'h00, 60'h000_0000_1234_5678, 18'h0_0005);
		check("pack", dest, 60'h405_0000_1234_5678);
		run_op(`SNP_OP_PACK, 6'h00, 60'hFFF_FFFF_EDCB_A987, 18'h0_0005);
		check("pack neg", dest, 60'hBFA_FFFF_EDCB_A987);
		run_op(`SNP_OP_MASK, 6'h00, 60'h000_0000_0000_0000, 18'h0_0000);
		check("mask 0", dest, 60'h000_0000_0000_0000);
		end_sim();
	end
endmodule

bind snp_unit snp_unit_assertions i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
	.start_i(start_i), .opcode_i(opcode_i), .immediate_shift_field_i(immediate_shift_field_i),
	.first_operand_reg_i(first_operand_reg_i), .second_operand_reg_i(second_operand_reg_i),
	.index_count_reg_i(index_count_reg_i), .next_instruction_fetch_i(next_instruction_fetch_i),
	.busy_o(busy_o), .common_write_phase_o(common_write_phase_o), .dest_operand_reg_o(dest_operand_reg_o),
	.index_write_o(index_write_o), .error_exit_flop_o(error_exit_flop_o),
	.instruction_hold_clear_o(instruction_hold_clear_o));

`default_nettype wire
